//--- asq_pkg.sv
/*
  Shared constants for the ADC sample and command sequencer: register
  pointers, configuration fields, reset values and conversion timing.
  Assumes a 100 MHz system clock and an open-drain two-wire serial link.
*/
// Contract
// - After reset the block is in sample mode with only channel 0 enabled.
// - Command and autocycle bits written equal select sample mode.
// - Falling convert-start in sample mode holds the input and starts converting.
// - A conversion takes about 550 ns, then track-and-hold returns to track.
// - Each sample-mode pulse converts the next enabled channel, lowest first.
// - Command bit 1 with autocycle bit 0 selects command mode.
// - In command mode a result register read triggers the next conversion.
// - Command conversion starts on first SCL rise after the ack, never during it.
// - First three bits sent name the converted channel.
// - In command mode the converter powers down after each conversion.
// - Sequence climbs from the lowest enabled channel and wraps forever.
// - A master nack stops sending and converting; configuration is kept.
// - After a stop, sequence resumes after the last channel unless rewritten.
// - Channel register write ends the sequence; next uses lowest new channel.
// - Result is two bytes: channel, alert, four MSBs; then eight LSBs.
// - Pointer 0x00 is result, 0x01 channel, 0x02 configuration.
// - Configuration 0x06 then 0x00 selects command mode.
// - Channel register bit n enables channel n.
// - Each command-mode result costs 18 SCL cycles.
// - Channel register takes one data byte; others take two, MSB first.
// - Once the pointer is set, any number of two-byte reads are served.
package asq_pkg;

  // -----------------------------------------------------------------
  // Register pointers
  // -----------------------------------------------------------------
  localparam logic [7:0] ASQ_PTR_RESULT = 8'h00;
  localparam logic [7:0] ASQ_PTR_CHAN = 8'h01;
  localparam logic [7:0] ASQ_PTR_CFG = 8'h02;

  // -----------------------------------------------------------------
  // Fields and reset values
  // -----------------------------------------------------------------
  localparam int ASQ_CFG_CMD_BIT = 10;
  localparam int ASQ_CFG_AUTO_BIT = 8;
  localparam logic [15:0] ASQ_CFG_RESET = 16'h0000;
  localparam logic [7:0] ASQ_CHAN_RESET = 8'h01;
  localparam logic [15:0] ASQ_WORD_ZERO = 16'h0000;
  localparam logic [7:0] ASQ_BYTE_ZERO = 8'h00;
  localparam logic [11:0] ASQ_DATA_ZERO = 12'h000;
  localparam logic ASQ_ALERT_NONE = 1'b0;
  localparam int ASQ_NUM_CH = 4;
  localparam logic [1:0] ASQ_CH_FIRST = 2'h0;
  localparam logic [1:0] ASQ_CH_LAST = 2'h3;
  // Arbitrary neutral bus address
  localparam logic [6:0] ASQ_DEF_SLAVE_ADDR = 7'h2F;

  // -----------------------------------------------------------------
  // Link framing counts
  // -----------------------------------------------------------------
  localparam logic [3:0] ASQ_BITS_BYTE = 4'h8;
  localparam logic [3:0] ASQ_BIT_RES_MSB = 4'h4;
  localparam logic [3:0] ASQ_CNT_ZERO = 4'h0;
  localparam logic [3:0] ASQ_CNT_ONE = 4'h1;
  localparam logic [1:0] ASQ_WIDX_PTR = 2'h0;
  localparam logic [1:0] ASQ_WIDX_HI = 2'h1;
  localparam logic [1:0] ASQ_WIDX_LO = 2'h2;

  // -----------------------------------------------------------------
  // Timing
  // -----------------------------------------------------------------
  localparam int ASQ_CLK_PERIOD_NS = 10;
  localparam int ASQ_CONV_TIME_NS = 550;
  localparam int ASQ_CONV_CYCLES =
    (ASQ_CONV_TIME_NS + ASQ_CLK_PERIOD_NS - 1) / ASQ_CLK_PERIOD_NS;
  localparam int ASQ_CNT_W = 8;

endpackage

//--- asq_buffer.sv
/*
  Small first-in first-out buffer with valid and ready on both sides.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module asq_buffer #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic push;
  logic pop;

  assign in_ready_o = (count_q != CW'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

//--- asq_sequencer.sv
/*
  Conversion control for a four-channel 12-bit converter: sample mode
  driven by the convert-start pin, command mode driven by result reads
  over the two-wire slave link, channel sequencing and result framing.
  Assumes SCL, SDA and convert-start are asynchronous pins, and an
  analog core that presents its code on adc_data_i at conversion end.
*/
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer
  import asq_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = ASQ_DEF_SLAVE_ADDR,
  parameter int CONV_CNT = ASQ_CONV_CYCLES
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic convert_start_n_i,
  input wire logic [11:0] adc_data_i,
  output logic track_hold_o,
  output logic adc_power_o,
  output logic [1:0] adc_channel_o
);

  typedef enum logic [2:0] {
    I2_IDLE, I2_ADDR, I2_ADDR_ACK, I2_WR, I2_WR_ACK, I2_RD, I2_RD_ACK
  } asq_link_t;

  // -----------------------------------------------------------------
  // Reset release and pin synchronisers
  // -----------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n;
  logic scl_m, scl_s, scl_p;
  logic sda_m, sda_s, sda_p;
  logic cs_m, cs_s, cs_p;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // Third stage only feeds edge detection, never the first stage
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
      {cs_m, cs_s, cs_p} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_p} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_i, sda_m, sda_s};
      {cs_m, cs_s, cs_p} <= {convert_start_n_i, cs_m, cs_s};
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, cs_fall;
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign bus_start = scl_s & scl_p & sda_p & ~sda_s;
  assign bus_stop = scl_s & scl_p & ~sda_p & sda_s;
  assign cs_fall = cs_p & ~cs_s;

  // -----------------------------------------------------------------
  // Shared state declarations
  // -----------------------------------------------------------------
  asq_link_t link_q;
  logic [7:0] shift_q, ptr_q, chan_q, cfg_hi_q;
  logic [15:0] cfg_q, res_word_q;
  logic [3:0] cnt_q;
  logic [1:0] widx_q;
  logic rw_q, rd_lo_q, acked_q, stretch_q, fresh_q;
  logic sda_drv_q, scl_drv_q;
  logic conv_busy_q, pending_q, restart_q;
  logic [ASQ_CNT_W-1:0] conv_cnt_q;
  logic [1:0] conv_ch_q, last_ch_q, next_ch;
  logic cmd_mode, sample_mode, chan_wr, wr_stb, conv_trig, conv_start, conv_done;
  logic buf_in_ready, buf_out_valid, buf_pop;
  logic [15:0] buf_out_data, rd_word, cur_res;
  logic [3:0] bit_idx;
  logic need_wait, rd_active;

  assign cmd_mode = cfg_q[ASQ_CFG_CMD_BIT] & ~cfg_q[ASQ_CFG_AUTO_BIT];
  assign sample_mode = cfg_q[ASQ_CFG_CMD_BIT] == cfg_q[ASQ_CFG_AUTO_BIT];
  assign rd_active = (link_q == I2_RD) || (link_q == I2_RD_ACK);

  // -----------------------------------------------------------------
  // Read data framing
  // -----------------------------------------------------------------
  // Until the fresh result lands, command reads show the channel only
  always_comb begin
    if (cmd_mode && !fresh_q) begin
      cur_res = {1'b0, pending_q ? conv_ch_q : next_ch, ASQ_ALERT_NONE,
                 ASQ_DATA_ZERO};
    end else begin
      cur_res = res_word_q;
    end
  end

  always_comb begin
    unique case (ptr_q)
      ASQ_PTR_RESULT: rd_word = cur_res;
      ASQ_PTR_CHAN: rd_word = {ASQ_BYTE_ZERO, chan_q};
      ASQ_PTR_CFG: rd_word = cfg_q;
      default: rd_word = ASQ_WORD_ZERO;
    endcase
  end

  // High byte first, then low byte
  assign bit_idx = {~rd_lo_q, 3'h7 - cnt_q[2:0]};
  assign need_wait = cmd_mode && !fresh_q && !rd_lo_q && (ptr_q == ASQ_PTR_RESULT)
                     && (cnt_q == ASQ_BIT_RES_MSB);
  assign wr_stb = (link_q == I2_WR) && scl_fall && (cnt_q == ASQ_BITS_BYTE);

  // -----------------------------------------------------------------
  // Two-wire slave engine
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= I2_IDLE;
      shift_q <= ASQ_BYTE_ZERO;
      cnt_q <= ASQ_CNT_ZERO;
      rw_q <= 1'b0;
      rd_lo_q <= 1'b0;
      acked_q <= 1'b0;
      stretch_q <= 1'b0;
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
    end else if (bus_stop) begin
      link_q <= I2_IDLE;
      sda_drv_q <= 1'b0;
      scl_drv_q <= 1'b0;
      stretch_q <= 1'b0;
    end else if (bus_start) begin
      link_q <= I2_ADDR;
      cnt_q <= ASQ_CNT_ZERO;
      rd_lo_q <= 1'b0;
      sda_drv_q <= 1'b0;
    end else if (stretch_q) begin
      // Clock held low until the converted code is in place; data
      // settles a cycle before the clock is let go, for setup time
      if (fresh_q) begin
        sda_drv_q <= ~rd_word[bit_idx];
        if (sda_drv_q == ~rd_word[bit_idx]) begin
          scl_drv_q <= 1'b0;
          stretch_q <= 1'b0;
        end
      end
    end else begin
      unique case (link_q)
        I2_IDLE: begin
          sda_drv_q <= 1'b0;
        end
        I2_ADDR, I2_WR: begin
          if (scl_rise && cnt_q != ASQ_BITS_BYTE) begin
            shift_q <= {shift_q[6:0], sda_s};
            cnt_q <= cnt_q + ASQ_CNT_ONE;
          end else if (scl_fall && cnt_q == ASQ_BITS_BYTE) begin
            if (link_q == I2_WR) begin
              link_q <= I2_WR_ACK;
              sda_drv_q <= 1'b1;
            end else if (shift_q[7:1] == SLAVE_ADDR) begin
              link_q <= I2_ADDR_ACK;
              rw_q <= shift_q[0];
              sda_drv_q <= 1'b1;
            end else begin
              link_q <= I2_IDLE;
            end
          end
        end
        I2_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_q <= ASQ_CNT_ZERO;
            if (rw_q) begin
              link_q <= I2_RD;
              sda_drv_q <= ~rd_word[{~rd_lo_q, 3'h7}];
            end else begin
              link_q <= I2_WR;
              sda_drv_q <= 1'b0;
            end
          end
        end
        I2_WR_ACK: begin
          if (scl_fall) begin
            link_q <= I2_WR;
            cnt_q <= ASQ_CNT_ZERO;
            sda_drv_q <= 1'b0;
          end
        end
        I2_RD: begin
          if (scl_rise) begin
            cnt_q <= cnt_q + ASQ_CNT_ONE;
          end else if (scl_fall) begin
            if (cnt_q == ASQ_BITS_BYTE) begin
              link_q <= I2_RD_ACK;
              rd_lo_q <= ~rd_lo_q;
              sda_drv_q <= 1'b0;
            end else if (need_wait) begin
              scl_drv_q <= 1'b1;
              stretch_q <= 1'b1;
            end else begin
              sda_drv_q <= ~rd_word[bit_idx];
            end
          end
        end
        I2_RD_ACK: begin
          if (scl_rise) begin
            acked_q <= ~sda_s;
          end else if (scl_fall) begin
            cnt_q <= ASQ_CNT_ZERO;
            if (acked_q) begin
              link_q <= I2_RD;
              sda_drv_q <= ~rd_word[{~rd_lo_q, 3'h7}];
            end else begin
              // Nack: go quiet, no further byte means no further conversion
              link_q <= I2_IDLE;
              sda_drv_q <= 1'b0;
            end
          end
        end
        default: link_q <= I2_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_o <= 1'b0;
      scl_oe_o <= 1'b0;
      sda_o <= 1'b0;
      scl_o <= 1'b0;
    end else begin
      sda_oe_o <= sda_drv_q;
      scl_oe_o <= scl_drv_q;
      sda_o <= 1'b0;
      scl_o <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // Register writes
  // -----------------------------------------------------------------
  // Channel register is a single byte; others take MSB then LSB
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= ASQ_PTR_RESULT;
      widx_q <= ASQ_WIDX_PTR;
      cfg_hi_q <= ASQ_BYTE_ZERO;
      cfg_q <= ASQ_CFG_RESET;
      chan_q <= ASQ_CHAN_RESET;
    end else if (bus_start) begin
      widx_q <= ASQ_WIDX_PTR;
    end else if (wr_stb) begin
      if (widx_q == ASQ_WIDX_PTR) begin
        ptr_q <= shift_q;
        widx_q <= ASQ_WIDX_HI;
      end else if (ptr_q == ASQ_PTR_CHAN) begin
        chan_q <= shift_q;
        widx_q <= ASQ_WIDX_PTR;
      end else if (widx_q == ASQ_WIDX_HI) begin
        cfg_hi_q <= shift_q;
        widx_q <= ASQ_WIDX_LO;
      end else begin
        if (ptr_q == ASQ_PTR_CFG) begin
          cfg_q <= {cfg_hi_q, shift_q};
        end
        widx_q <= ASQ_WIDX_PTR;
      end
    end
  end

  assign chan_wr = wr_stb && (widx_q != ASQ_WIDX_PTR) && (ptr_q == ASQ_PTR_CHAN);

  // -----------------------------------------------------------------
  // Channel sequencer
  // -----------------------------------------------------------------
  always_comb begin
    logic found_lo;
    logic found_up;
    logic [1:0] lo_ch;
    logic [1:0] up_ch;
    found_lo = 1'b0;
    found_up = 1'b0;
    lo_ch = ASQ_CH_FIRST;
    up_ch = ASQ_CH_FIRST;
    for (int i = ASQ_NUM_CH - 1; i >= 0; i--) begin
      if (chan_q[i]) begin
        found_lo = 1'b1;
        lo_ch = 2'(i);
        if (2'(i) > last_ch_q) begin
          found_up = 1'b1;
          up_ch = 2'(i);
        end
      end
    end
    // Wrap to the lowest enabled channel after the highest
    if (restart_q || !found_up) begin
      next_ch = found_lo ? lo_ch : ASQ_CH_FIRST;
    end else begin
      next_ch = up_ch;
    end
  end

  // Channel write wins over a simultaneous start so no rewrite is lost
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      last_ch_q <= ASQ_CH_LAST;
      restart_q <= 1'b1;
    end else begin
      if (conv_start) begin
        last_ch_q <= next_ch;
      end
      if (chan_wr) begin
        restart_q <= 1'b1;
      end else if (conv_start) begin
        restart_q <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // Conversion control
  // -----------------------------------------------------------------
  // First SCL rise of a result high byte, after the previous ack
  assign conv_trig = cmd_mode && (link_q == I2_RD) && scl_rise && !stretch_q
                     && (cnt_q == ASQ_CNT_ZERO) && !rd_lo_q
                     && (ptr_q == ASQ_PTR_RESULT);
  // Buffer back-pressure refuses a start rather than lose a result
  assign conv_start = !conv_busy_q && buf_in_ready
                      && ((sample_mode && cs_fall) || conv_trig);
  assign conv_done = conv_busy_q && (conv_cnt_q == ASQ_CNT_W'(CONV_CNT - 1));

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      conv_busy_q <= 1'b0;
      conv_cnt_q <= '0;
      conv_ch_q <= ASQ_CH_FIRST;
    end else if (conv_start) begin
      conv_busy_q <= 1'b1;
      conv_cnt_q <= '0;
      conv_ch_q <= next_ch;
    end else if (conv_done) begin
      conv_busy_q <= 1'b0;
    end else if (conv_busy_q) begin
      conv_cnt_q <= conv_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      track_hold_o <= 1'b0;
      adc_power_o <= 1'b1;
      adc_channel_o <= ASQ_CH_FIRST;
    end else begin
      if (conv_start) begin
        track_hold_o <= 1'b1;
        adc_power_o <= 1'b1;
        adc_channel_o <= next_ch;
      end else if (conv_done) begin
        track_hold_o <= 1'b0;
        adc_power_o <= !cmd_mode;
      end else if (!conv_busy_q) begin
        adc_power_o <= !cmd_mode;
      end
    end
  end

  // -----------------------------------------------------------------
  // Result buffer and result register
  // -----------------------------------------------------------------
  asq_buffer #(
    .WIDTH(16),
    .DEPTH(2)
  ) u_buffer (
    .clock_i(clock_i),
    .rst_n_i(rst_n),
    .in_valid_i(conv_done),
    .in_ready_o(buf_in_ready),
    .in_data_i({1'b0, conv_ch_q, ASQ_ALERT_NONE, adc_data_i}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out_data)
  );

  // Outside command mode a word in flight on the link is never swapped underneath it
  assign buf_pop = buf_out_valid
                   && (cmd_mode ? pending_q : !(rd_active && ptr_q == ASQ_PTR_RESULT));

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      res_word_q <= ASQ_WORD_ZERO;
      pending_q <= 1'b0;
      fresh_q <= 1'b0;
    end else begin
      if (buf_pop) begin
        res_word_q <= buf_out_data;
      end
      if (conv_trig && conv_start) begin
        pending_q <= 1'b1;
      end else if (buf_pop) begin
        pending_q <= 1'b0;
      end
      // Stale until the next result lands for this lot
      if (buf_pop && pending_q) begin
        fresh_q <= 1'b1;
      end else if ((link_q == I2_RD && scl_fall && cnt_q == ASQ_BITS_BYTE && rd_lo_q)
                   || (link_q == I2_ADDR && scl_fall && cnt_q == ASQ_BITS_BYTE)) begin
        fresh_q <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

//--- asq_sequencer_assertions.sv
/*
  Port checker for asq_sequencer: conversion timing, channel
  stability, link drive timing and clock stretching.
  Assumes binding to every asq_sequencer instance.
*/
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer_assertions #(
  parameter int CONV_CNT = 55
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic convert_start_n_i,
  input wire logic [11:0] adc_data_i,
  input wire logic track_hold_o,
  input wire logic adc_power_o,
  input wire logic [1:0] adc_channel_o
);
  // ----------------------------------------
  // Hold length counter and sequences
  // ----------------------------------------
  localparam int MAX_STRETCH = 400;
  logic [15:0] hold_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_q <= 16'h0000;
    end else if (track_hold_o) begin
      hold_q <= hold_q + 16'h0001;
    end else begin
      hold_q <= 16'h0000;
    end
  end
  sequence s_start;
    $rose(track_hold_o);
  endsequence
  sequence s_hold;
    track_hold_o [*4];
  endsequence
  chk_hold_length: assert property ($fell(track_hold_o) |-> hold_q == CONV_CNT)
    else $error("hold time differs from conversion count");
  chk_hold_min: assert property (s_start |-> s_hold)
    else $error("hold dropped too early");
  chk_power_conv: assert property (track_hold_o |-> adc_power_o)
    else $error("converting while powered down");
  chk_chan_stable: assert property (track_hold_o && $past(track_hold_o) |-> $stable(adc_channel_o))
    else $error("channel moved during conversion");
  chk_chan_update: assert property ($changed(adc_channel_o) |-> track_hold_o)
    else $error("channel moved outside a conversion start");
  chk_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data line changed while clock high");
  chk_stretch_low: assert property ($rose(scl_oe_o) |-> !scl_i)
    else $error("stretch began with clock high");
  chk_stretch_bound: assert property (scl_oe_o |-> ##[0:MAX_STRETCH] !scl_oe_o)
    else $error("clock stretch too long");
  chk_release_done: assert property ($fell(scl_oe_o) |-> !track_hold_o)
    else $error("stretch released before result ready");
endmodule
bind asq_sequencer asq_sequencer_assertions #(.CONV_CNT(CONV_CNT)) i_asq_sequencer_assertions (
  .clock_i(clock_i), .nrst_i(nrst_i), .scl_i(scl_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .convert_start_n_i(convert_start_n_i),
  .adc_data_i(adc_data_i), .track_hold_o(track_hold_o), .adc_power_o(adc_power_o),
  .adc_channel_o(adc_channel_o));
`default_nettype wire

//--- asq_i2c_master.sv
/*
  Behavioural two-wire bus master, the far side of asq_sequencer.
  Assumes the bench resolves both open-drain wires with pull-ups.
*/
`timescale 1ns/1ps
`default_nettype none
module asq_i2c_master (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic hung_o
);
  // ----------------------------------------
  // Bit and byte framing, 125 ns clock
  // ----------------------------------------
  localparam realtime QTR = 31.25;
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    hung_o = 1'b0;
  end
  // Clock stands still between frames; stretch wait is bounded
  task automatic bit_io(input logic b, output logic r);
    int i;
    #QTR sda_oe_o = !b;
    #QTR scl_oe_o = 1'b0;
    for (i = 0; i < 400 && scl_i !== 1'b1; i++)
      #10;
    if (i == 400)
      hung_o = 1'b1;
    #QTR r = sda_i;
    #QTR scl_oe_o = 1'b1;
  endtask
  // Also a repeated start when the clock is low
  task automatic start();
    #(2*QTR) sda_oe_o = 1'b0;
    #(2*QTR) scl_oe_o = 1'b0;
    #(2*QTR) sda_oe_o = 1'b1;
    #(2*QTR) scl_oe_o = 1'b1;
  endtask
  task automatic stop();
    #QTR sda_oe_o = 1'b1;
    #QTR scl_oe_o = 1'b0;
    #(2*QTR) sda_oe_o = 1'b0;
    #(2*QTR);
  endtask
  // Nine clocks per byte, two bytes per result
  task automatic tx(input logic [7:0] d, output logic nak);
    for (int k = 7; k >= 0; k--)
      bit_io(d[k], nak);
    bit_io(1'b1, nak);
  endtask
  task automatic rx(input logic ack, output logic [7:0] d);
    logic r;
    for (int k = 7; k >= 0; k--)
      bit_io(1'b1, d[k]);
    bit_io(!ack, r);
  endtask
endmodule
`default_nettype wire

//--- asq_sequencer_tb.sv
/*
  Self-checking bench for asq_sequencer: register access, sample
  and command mode sequencing over the two-wire link.
  Assumes asq_i2c_master as the far side and a pull-up per wire.
*/
`timescale 1ns/1ps
`default_nettype none
module asq_sequencer_tb;
  import asq_pkg::*;
  localparam int CONV = ASQ_CONV_CYCLES;
  logic clock_i, nrst_i, convert_start_n_i, scl_lo, sda_lo;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, hung, track_hold, adc_power, nak;
  logic [1:0] ch;
  logic [11:0] adc_data;
  int err_count = 0;
  int checks_done = 0;
  wire logic scl = !(scl_oe | m_scl_oe);
  wire logic sda = !(sda_oe | m_sda_oe);
  assign adc_data = {4'hA, 6'h00, ch};
  asq_sequencer #(.CONV_CNT(CONV)) i_asq_sequencer (.clock_i(clock_i), .nrst_i(nrst_i),
    .scl_i(scl), .scl_o(scl_lo), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_lo),
    .sda_oe_o(sda_oe),
    .convert_start_n_i(convert_start_n_i), .adc_data_i(adc_data), .track_hold_o(track_hold),
    .adc_power_o(adc_power), .adc_channel_o(ch));
  asq_i2c_master i_asq_i2c_master (.scl_i(scl), .sda_i(sda), .scl_oe_o(m_scl_oe),
    .sda_oe_o(m_sda_oe), .hung_o(hung));
  // A hung link ends the run at once
  always @(posedge hung) test_done();
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  function automatic logic [15:0] ew(input logic [1:0] c);
    return {1'b0, c, 1'b0, 4'hA, 6'h00, c};
  endfunction
  task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    if (hung)
      err_count++;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n, input logic sp);
    i_asq_i2c_master.start();
    i_asq_i2c_master.tx({ASQ_DEF_SLAVE_ADDR, 1'b0}, nak);
    check("address ack", 16'h0000, {15'h0000, nak});
    i_asq_i2c_master.tx(p, nak);
    if (n == 2)
      i_asq_i2c_master.tx(d[15:8], nak);
    if (n > 0)
      i_asq_i2c_master.tx(d[7:0], nak);
    check("data ack", 16'h0000, {15'h0000, nak});
    if (sp)
      i_asq_i2c_master.stop();
  endtask
  task automatic rd(input int n, input logic [63:0] e);
    logic [15:0] w;
    i_asq_i2c_master.start();
    i_asq_i2c_master.tx({ASQ_DEF_SLAVE_ADDR, 1'b1}, nak);
    for (int k = 0; k < n; k++) begin
      i_asq_i2c_master.rx(1'b1, w[15:8]);
      i_asq_i2c_master.rx(k < n - 1, w[7:0]);
      check("read word", e[63-16*k -: 16], w);
    end
    i_asq_i2c_master.stop();
  endtask
  task automatic wait_th(input logic v);
    int i;
    for (i = 0; i < 200 && track_hold !== v; i++)
      @(posedge clock_i);
    if (i == 200) begin
      err_count++;
      test_done();
    end
  endtask
  // Next pulse only after the previous result was read
  task automatic pulse();
    @(posedge clock_i) #1 convert_start_n_i = 1'b0;
    wait_th(1'b1);
    @(posedge clock_i) #1 convert_start_n_i = 1'b1;
    wait_th(1'b0);
    repeat (5) @(posedge clock_i);
  endtask
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    nrst_i = 1'b0;
    convert_start_n_i = 1'b1;
    repeat (6) @(posedge clock_i);
    #1 nrst_i = 1'b1;
    repeat (10) @(posedge clock_i);
    wr(8'h02, 16'h0000, 0, 1);
    rd(1, {16'h0000, 48'h0});
    wr(8'h01, 16'h0000, 0, 1);
    rd(1, {16'h0001, 48'h0});
    wr(8'h05, 16'h0000, 0, 1);
    rd(1, {16'h0000, 48'h0});
    $display("reset values test done");
    wr(8'h00, 16'h0000, 0, 1);
    pulse();
    rd(1, {ew(2'h0), 48'h0});
    wr(8'h01, 16'h0006, 1, 1);
    wr(8'h00, 16'h0000, 0, 1);
    for (int k = 0; k < 3; k++) begin
      pulse();
      rd(1, {ew(2'(k % 2 + 1)), 48'h0});
    end
    $display("sample mode test done");
    wr(8'h02, 16'h0600, 2, 1);
    wr(8'h01, 16'h0007, 1, 1);
    wr(8'h00, 16'h0000, 0, 0);
    rd(4, {ew(2'h0), ew(2'h1), ew(2'h2), ew(2'h0)});
    check("power", 16'h0000, {15'h0000, adc_power});
    rd(1, {ew(2'h1), 48'h0});
    wr(8'h01, 16'h000C, 1, 1);
    wr(8'h00, 16'h0000, 0, 0);
    rd(2, {ew(2'h2), ew(2'h3), 32'h0});
    wr(8'h02, 16'h0000, 0, 1);
    rd(1, {16'h0600, 48'h0});
    $display("command mode test done");
    wr(8'h02, 16'h0500, 2, 1);
    wr(8'h01, 16'h0002, 1, 1);
    wr(8'h00, 16'h0000, 0, 1);
    pulse();
    rd(1, {ew(2'h1), 48'h0});
    check("open drain", 16'h0000, {14'h0000, scl_lo, sda_lo});
    $display("mode return test done");
    test_done();
  end
endmodule
`default_nettype wire
